// ==== common/seq_pkg.sv ====
// Operation
// RL1: combined sequence: one transmit, turnaround, one receive
// RL2: transmit half equals standalone transmit sequence
// RL3: plain receive half equals standalone receive
// RL4: ack-only accepts matching acknowledge, else resumes search
// RL5: ack-only stores nothing unless accept-all set
// RL6: ack-only variant ends with receive-done event
// RL7: host picks ack-only only when ack requested
// RL8: continuous assessment repeats, 126 us gap
// RL9: busy updates status only, idle raises channel event
// RL10: continuous ignores slotted, aborts on enabled timeout
// RL11: continuous uses assessment modes one to three
// RL12: timed start, warmup, settle, strobe, record result
// RL13: on idle: channel event, warmdown, sequence done
// RL14: busy bit sampled only at measurement end
// RL15: busy iteration count readable by software
// RL16: hold one enable per sub-manager during operation
// RL17: sub-managers idle within 2 us of disable
// RL18: aborts drop all enables, staged transmit warmdown
// RL19: sequencer and sub-managers share one clock
// RL20: switch stage a: synth off, new channel, 4us
// RL21: switch stage b: synth on, no lock, 52us
// RL22: whole channel change takes 56 us
// RL23: method 00 energy, 01..11 modes one-three
// RL24: state durations counted in clock cycles
package seq_pkg;
  localparam int CLK_MHZ = 125;
  localparam int RX_WARM_US = 144;
  localparam int TX_WARM_US = 100;
  localparam int TURN_US = 12;
  localparam int SETTLE_US = 26;
  localparam int GAP_US = 126;
  localparam int SLOT_US = 320;
  localparam int SWA_US = 4;
  localparam int SWB_US = 52;
  localparam int STAGE_US = 2;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int TURN_CYC = TURN_US * CLK_MHZ;
  localparam int SWA_CYC = SWA_US * CLK_MHZ;
  localparam int STAGE_CYC = STAGE_US * CLK_MHZ;
  // register indices (byte address = 4 * index)
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_STAT = 3'h1;
  localparam logic [2:0] IDX_EVT = 3'h2;
  localparam logic [2:0] IDX_BCNT = 3'h3;
  localparam logic [2:0] IDX_CH0 = 3'h4;
  localparam logic [2:0] IDX_CH1 = 3'h5;
  // control fields
  localparam int F_ACKONLY = 4;
  localparam int F_CCATX = 5;
  localparam int F_SLOT = 6;
  localparam int F_ALL = 7;
  localparam int F_TOEN = 8;
  localparam int F_TIMED = 9;
  localparam int F_METH = 10;
  localparam int F_NET = 12;
  // event bits
  localparam int E_RX = 0;
  localparam int E_TX = 1;
  localparam int E_CHAN = 2;
  localparam int E_SEQ = 3;
  // sequence select codes
  localparam logic [2:0] SEL_IDLE = 3'h0;
  localparam logic [2:0] SEL_R = 3'h1;
  localparam logic [2:0] SEL_T = 3'h2;
  localparam logic [2:0] SEL_C = 3'h3;
  localparam logic [2:0] SEL_TR = 3'h4;
  localparam logic [2:0] SEL_CCCA = 3'h5;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
endpackage : seq_pkg

// ==== rtl/radio_sequence_manager.sv ====
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
module radio_sequence_manager #(
  parameter int RX_WARM_CYC = seq_pkg::RX_WARM_US * seq_pkg::CLK_MHZ,
  parameter int TX_WARM_CYC = seq_pkg::TX_WARM_US * seq_pkg::CLK_MHZ,
  parameter int GAP_CYC = seq_pkg::GAP_US * seq_pkg::CLK_MHZ,
  parameter int SLOT_CYC = seq_pkg::SLOT_US * seq_pkg::CLK_MHZ,
  parameter int SWB_CYC = seq_pkg::SWB_US * seq_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // radio front logic status
  input wire logic assess_done,
  input wire logic assess_busy,
  input wire logic tx_frame_done,
  input wire logic rx_frame_end,
  input wire logic rx_frame_ok,
  input wire logic rx_ack_match,
  input wire logic rx_ack_wanted,
  input wire logic rx_pre_search,
  input wire logic pan_switch_req,
  input wire logic timeout_compare_timer,
  input wire logic start_compare,
  input wire logic synth_unlock,
  // sub-manager enables
  output logic receive_manager_enable,
  output logic transmit_manager_enable,
  output logic synth_manager_enable,
  output logic lock_detect_enable,
  output logic pa_enable,
  // channel assess unit
  output logic assess_strobe,
  output logic energy_detect_select,
  output logic assess_mode_one_select,
  output logic assess_mode_two_select,
  output logic assess_mode_three_select,
  // synthesizer and packet buffer
  output logic [6:0] synth_integer_word,
  output logic [15:0] synth_fraction_word,
  output logic buffer_write_enable
);

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_START = 4'h1, S_RXWARM = 4'h3, S_SETTLE = 4'h2,
    S_MEAS = 4'h6, S_GAP = 4'h7, S_TXWARM = 4'h5, S_TXRUN = 4'h4,
    S_TURN = 4'hc, S_RXRUN = 4'hd, S_SWA = 4'hf, S_SWB = 4'he,
    S_STAGED = 4'ha
  } state_t;

  typedef struct packed {
    state_t st;
    logic [15:0] cnt;
    logic [15:0] slot;
    logic [2:0] sel;
    logic ack_only;
    logic cca_tx;
    logic slotted;
    logic accept_all;
    logic to_en;
    logic timed;
    logic [1:0] method;
    logic network;
    logic [22:0] chan0;
    logic [22:0] chan1;
    logic busy;
    logic [3:0] ev;
    logic [15:0] busy_cnt;
    logic second;
    logic ack_tx;
    logic rx_half;
    logic rx_en;
    logic tx_en;
    logic syn_en;
    logic lock_en;
    logic pa_en;
    logic strobe;
    logic buf_wr;
    logic [3:0] mode;
    logic [6:0] syn_int;
    logic [15:0] syn_frac;
    logic aphase;
    logic awr;
    logic amap;
    logic [2:0] aidx;
    logic [31:0] rdata;
  } regs_t;

  regs_t q_r;
  regs_t q_nxt;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [3:0] mode_of(input logic [1:0] m, input logic cont);
    logic [3:0] r;
    r = 4'h0;
    if (m == 2'h0 && cont) begin
      r = 4'h2;
    end else begin
      r[m] = 1'b1;
    end
    return r;
  endfunction : mode_of

  function automatic logic [15:0] ld(input int n);
    return n > 0 ? 16'(n - 1) : 16'h0000;
  endfunction : ld

  logic cnt_zero;
  logic wr_ctrl;
  logic sw_abort;
  logic hw_abort;
  logic active;
  logic is_ccca;
  logic is_tr;

  assign cnt_zero = q_r.cnt == seq_pkg::CNT_ZERO;
  assign active = q_r.st != S_IDLE;
  assign is_ccca = q_r.sel == seq_pkg::SEL_CCCA;
  assign is_tr = q_r.sel == seq_pkg::SEL_TR;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.strobe = 1'b0;
    q_nxt.cnt = cnt_zero ? seq_pkg::CNT_ZERO : q_r.cnt - seq_pkg::CNT_ONE;
    q_nxt.slot = (q_r.slot == seq_pkg::CNT_ZERO) ? q_r.slot : q_r.slot - seq_pkg::CNT_ONE;
    wr_ctrl = 1'b0;
    sw_abort = 1'b0;

    // bus data phase
    if (q_r.aphase && q_r.awr && q_r.amap) begin
      unique case (q_r.aidx)
        seq_pkg::IDX_CTRL: begin
          wr_ctrl = 1'b1;
          if (!active) begin
            q_nxt.sel = hwdata[2:0];
            q_nxt.ack_only = hwdata[seq_pkg::F_ACKONLY];
            q_nxt.cca_tx = hwdata[seq_pkg::F_CCATX];
            q_nxt.slotted = hwdata[seq_pkg::F_SLOT];
            q_nxt.accept_all = hwdata[seq_pkg::F_ALL];
            q_nxt.to_en = hwdata[seq_pkg::F_TOEN];
            q_nxt.timed = hwdata[seq_pkg::F_TIMED];
            q_nxt.method = hwdata[seq_pkg::F_METH +: 2];
            q_nxt.network = hwdata[seq_pkg::F_NET];
          end else if (hwdata[2:0] == seq_pkg::SEL_IDLE) begin
            sw_abort = 1'b1;
          end
        end
        seq_pkg::IDX_EVT: q_nxt.ev = q_r.ev & ~hwdata[3:0];
        seq_pkg::IDX_CH0: q_nxt.chan0 = hwdata[22:0];
        seq_pkg::IDX_CH1: q_nxt.chan1 = hwdata[22:0];
        default: ;
      endcase
    end

    // sequence start
    if (wr_ctrl && !active && hwdata[2:0] != seq_pkg::SEL_IDLE) begin
      q_nxt.second = 1'b0;
      q_nxt.ack_tx = 1'b0;
      q_nxt.rx_half = 1'b0;
      q_nxt.busy_cnt = 16'h0000;
      q_nxt.syn_int = hwdata[seq_pkg::F_NET] ? q_r.chan1[22:16] : q_r.chan0[22:16];
      q_nxt.syn_frac = hwdata[seq_pkg::F_NET] ? q_r.chan1[15:0] : q_r.chan0[15:0];
      if (hwdata[seq_pkg::F_TIMED]) begin
        q_nxt.st = S_START; // RL12
      end else if ((hwdata[2:0] == seq_pkg::SEL_T || hwdata[2:0] == seq_pkg::SEL_TR) &&
                   !hwdata[seq_pkg::F_CCATX]) begin
        q_nxt.st = S_TXWARM; // RL2
        q_nxt.cnt = ld(TX_WARM_CYC);
      end else begin
        q_nxt.st = S_RXWARM;
        q_nxt.cnt = ld(RX_WARM_CYC);
      end
    end

    unique case (q_r.st)
      S_IDLE: ;
      S_START: begin
        if (start_compare) begin // RL12
          if ((is_tr || q_r.sel == seq_pkg::SEL_T) && !q_r.cca_tx) begin
            q_nxt.st = S_TXWARM;
            q_nxt.cnt = ld(TX_WARM_CYC);
          end else begin
            q_nxt.st = S_RXWARM;
            q_nxt.cnt = ld(RX_WARM_CYC);
          end
        end
      end
      S_RXWARM: begin
        if (cnt_zero) begin
          if (q_r.sel == seq_pkg::SEL_R || q_r.rx_half) begin
            q_nxt.st = S_RXRUN;
          end else begin
            q_nxt.st = S_SETTLE; // RL12
            q_nxt.cnt = ld(seq_pkg::SETTLE_CYC);
            q_nxt.slot = ld(SLOT_CYC);
          end
        end
      end
      S_SETTLE: begin
        if (cnt_zero) begin
          q_nxt.st = S_MEAS;
          q_nxt.strobe = 1'b1; // RL12
        end
      end
      S_MEAS: begin
        if (assess_done) begin
          q_nxt.busy = assess_busy; // RL14
          if (is_ccca && assess_busy) begin
            q_nxt.busy_cnt = q_r.busy_cnt + 16'h0001; // RL15
            q_nxt.st = S_GAP; // RL8 RL9
            q_nxt.cnt = ld(GAP_CYC);
          end else if (is_ccca || q_r.sel == seq_pkg::SEL_C || assess_busy) begin
            q_nxt.ev[seq_pkg::E_CHAN] = 1'b1; // RL13
            q_nxt.ev[seq_pkg::E_SEQ] = 1'b1;
            q_nxt.sel = seq_pkg::SEL_IDLE;
            q_nxt.st = S_IDLE;
          end else if (q_r.slotted && !q_r.second) begin
            q_nxt.second = 1'b1; // RL2
            q_nxt.st = S_GAP;
          end else begin
            q_nxt.ev[seq_pkg::E_CHAN] = 1'b1;
            q_nxt.st = S_TXWARM;
            q_nxt.cnt = ld(TX_WARM_CYC);
          end
        end
      end
      S_GAP: begin
        if (is_ccca ? cnt_zero : q_r.slot == seq_pkg::CNT_ZERO) begin
          q_nxt.st = S_MEAS; // RL8
          q_nxt.strobe = 1'b1;
        end
      end
      S_TXWARM: begin
        if (cnt_zero) begin
          q_nxt.st = S_TXRUN;
        end
      end
      S_TXRUN: begin
        if (tx_frame_done) begin
          q_nxt.ev[seq_pkg::E_TX] = 1'b1;
          if (is_tr && !q_r.ack_tx) begin
            q_nxt.st = S_TURN; // RL1
            q_nxt.cnt = ld(seq_pkg::TURN_CYC);
            q_nxt.rx_half = 1'b1;
          end else begin
            q_nxt.ev[seq_pkg::E_SEQ] = 1'b1;
            q_nxt.sel = seq_pkg::SEL_IDLE;
            q_nxt.st = S_IDLE;
          end
        end
      end
      S_TURN: begin
        if (cnt_zero) begin
          q_nxt.st = S_RXWARM; // RL1
          q_nxt.cnt = ld(RX_WARM_CYC);
        end
      end
      S_RXRUN: begin
        if (rx_frame_end && rx_frame_ok && !(is_tr && q_r.ack_only && !rx_ack_match)) begin
          q_nxt.ev[seq_pkg::E_RX] = 1'b1; // RL6
          if (rx_ack_wanted && !(is_tr && q_r.ack_only)) begin
            q_nxt.ack_tx = 1'b1; // RL3
            q_nxt.st = S_TXWARM;
            q_nxt.cnt = ld(TX_WARM_CYC);
          end else begin
            q_nxt.ev[seq_pkg::E_SEQ] = 1'b1;
            q_nxt.sel = seq_pkg::SEL_IDLE;
            q_nxt.st = S_IDLE;
          end
        end else if (pan_switch_req && rx_pre_search && q_r.sel == seq_pkg::SEL_R) begin
          q_nxt.st = S_SWA; // RL20
          q_nxt.cnt = ld(seq_pkg::SWA_CYC);
          q_nxt.network = ~q_r.network;
          q_nxt.syn_int = q_r.network ? q_r.chan0[22:16] : q_r.chan1[22:16];
          q_nxt.syn_frac = q_r.network ? q_r.chan0[15:0] : q_r.chan1[15:0];
        end
      end
      S_SWA: begin
        if (cnt_zero) begin
          q_nxt.st = S_SWB; // RL21
          q_nxt.cnt = ld(SWB_CYC);
        end
      end
      S_SWB: begin
        if (cnt_zero) begin
          q_nxt.st = S_RXRUN; // RL22
        end
      end
      S_STAGED: begin
        if (cnt_zero) begin
          q_nxt.st = S_IDLE; // RL18
        end
      end
      default: q_nxt.st = S_IDLE;
    endcase

    // aborts
    hw_abort = active && ((q_r.lock_en && synth_unlock) ||
               (q_r.to_en && timeout_compare_timer && q_r.sel != seq_pkg::SEL_C)); // RL10
    if ((sw_abort || hw_abort) && q_r.st != S_STAGED) begin
      q_nxt.sel = seq_pkg::SEL_IDLE;
      q_nxt.strobe = 1'b0;
      if (q_r.st == S_TXWARM || q_r.st == S_TXRUN) begin
        q_nxt.st = S_STAGED; // RL18
        q_nxt.cnt = ld(seq_pkg::STAGE_CYC);
      end else begin
        q_nxt.st = S_IDLE; // RL18
      end
    end

    // enables from next state
    q_nxt.rx_en = q_nxt.st inside {S_RXWARM, S_SETTLE, S_MEAS, S_GAP, S_RXRUN, S_SWA, S_SWB}; // RL16 RL17
    q_nxt.tx_en = q_nxt.st inside {S_TXWARM, S_TXRUN, S_STAGED}; // RL16
    q_nxt.syn_en = !(q_nxt.st inside {S_IDLE, S_START, S_SWA}); // RL20 RL21
    q_nxt.lock_en = !(q_nxt.st inside {S_IDLE, S_START, S_SWA, S_SWB, S_STAGED}); // RL21
    q_nxt.pa_en = q_nxt.st == S_TXRUN; // RL18
    q_nxt.buf_wr = q_nxt.st == S_RXRUN &&
                   (!(q_nxt.sel == seq_pkg::SEL_TR && q_r.ack_only) || q_r.accept_all); // RL5 RL3
    q_nxt.mode = (q_nxt.st inside {S_SETTLE, S_MEAS, S_GAP, S_RXWARM} && !q_nxt.rx_half &&
                  q_nxt.sel != seq_pkg::SEL_R) ?
                 mode_of(q_nxt.method, q_nxt.sel == seq_pkg::SEL_CCCA) : 4'h0; // RL11 RL23

    // bus address phase and read data
    q_nxt.aphase = hsel && hready && htrans[1];
    q_nxt.awr = hwrite;
    q_nxt.aidx = haddr[4:2];
    q_nxt.amap = haddr[31:5] == 27'h0 && haddr[4:2] <= seq_pkg::IDX_CH1;
    q_nxt.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[31:2])
        30'(seq_pkg::IDX_CTRL): q_nxt.rdata = {19'h0, q_r.network, q_r.method, q_r.timed, q_r.to_en,
                                              q_r.accept_all, q_r.slotted, q_r.cca_tx, q_r.ack_only,
                                              1'b0, q_r.sel};
        30'(seq_pkg::IDX_STAT): q_nxt.rdata = {27'h0, q_r.st, q_r.busy};
        30'(seq_pkg::IDX_EVT): q_nxt.rdata = {28'h0, q_r.ev};
        30'(seq_pkg::IDX_BCNT): q_nxt.rdata = {16'h0, q_r.busy_cnt};
        30'(seq_pkg::IDX_CH0): q_nxt.rdata = {9'h0, q_r.chan0};
        30'(seq_pkg::IDX_CH1): q_nxt.rdata = {9'h0, q_r.chan1};
        default: ;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q_r <= '0;
      q_r.st <= S_IDLE;
    end else begin
      q_r <= q_nxt; // RL19 RL24
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q_r.rdata;
  assign receive_manager_enable = q_r.rx_en;
  assign transmit_manager_enable = q_r.tx_en;
  assign synth_manager_enable = q_r.syn_en;
  assign lock_detect_enable = q_r.lock_en;
  assign pa_enable = q_r.pa_en;
  assign assess_strobe = q_r.strobe;
  assign energy_detect_select = q_r.mode[0];
  assign assess_mode_one_select = q_r.mode[1];
  assign assess_mode_two_select = q_r.mode[2];
  assign assess_mode_three_select = q_r.mode[3];
  assign synth_integer_word = q_r.syn_int;
  assign synth_fraction_word = q_r.syn_frac;
  assign buffer_write_enable = q_r.buf_wr;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_busy_count: assert property (q_r.st == S_MEAS && is_ccca && assess_done && assess_busy && !hw_abort
    && !sw_abort |=> q_r.busy_cnt == $past(q_r.busy_cnt) + 16'h0001 && q_r.st == S_GAP) // RL15
    else $error("busy count not advanced");
  a_busy_no_event: assert property (q_r.st == S_MEAS && is_ccca && assess_done && assess_busy
    |=> !$rose(q_r.ev[seq_pkg::E_CHAN])) // RL9
    else $error("channel event on busy");
  a_idle_finish: assert property (q_r.st == S_MEAS && is_ccca && assess_done && !assess_busy && !hw_abort
    && !sw_abort |=> q_r.ev[seq_pkg::E_CHAN] && q_r.ev[seq_pkg::E_SEQ] && !q_r.rx_en) // RL13
    else $error("idle result not finished");
  a_busy_sampled: assert property ($changed(q_r.busy) |-> $past(q_r.st == S_MEAS && assess_done)) // RL14
    else $error("busy bit changed mid measurement");
  a_gap_strobe: assert property (q_r.st == S_GAP && is_ccca && cnt_zero && !hw_abort && !sw_abort
    |=> q_r.st == S_MEAS && q_r.strobe) // RL8
    else $error("gap end without strobe");
  a_swa_synth_off: assert property (q_r.st == S_SWA |-> !q_r.syn_en && !q_r.lock_en && q_r.rx_en) // RL20
    else $error("synth on in stage a");
  a_swb_no_lock: assert property ($rose(q_r.st == S_SWB) |-> q_r.syn_en && !q_r.lock_en
    && q_r.cnt == ld(SWB_CYC)) // RL21
    else $error("stage b entry wrong");
  a_ack_nostore: assert property (q_r.st == S_RXRUN && is_tr && q_r.ack_only && !q_r.accept_all
    |-> !q_r.buf_wr) // RL5
    else $error("ack-only stored data");
  a_ack_mismatch: assert property (q_r.st == S_RXRUN && is_tr && q_r.ack_only && rx_frame_end
    && rx_frame_ok && !rx_ack_match && !hw_abort && !sw_abort && !pan_switch_req
    |=> q_r.st == S_RXRUN && q_r.rx_en && !$rose(q_r.ev[seq_pkg::E_RX])) // RL4
    else $error("mismatch not discarded");
  a_no_energy: assert property (is_ccca |-> !energy_detect_select) // RL11
    else $error("energy detect in continuous");
  a_abort_off: assert property (sw_abort && q_r.st == S_RXRUN |=> !q_r.rx_en && !q_r.tx_en
    && !q_r.syn_en) // RL18
    else $error("abort left enables on");

  c_ccca_retry: cover property (q_r.st == S_GAP && is_ccca ##1 q_r.st == S_MEAS);
  c_chan_switch: cover property (q_r.st == S_SWB ##1 q_r.st == S_RXRUN);
  c_tr_receive: cover property (q_r.st == S_TURN ##1 q_r.st == S_RXWARM);
  c_staged: cover property (q_r.st == S_STAGED);

endmodule : radio_sequence_manager

// ==== tb/radio_front_model.sv ====
`timescale 1ns/10ps
module radio_front_model #(
  parameter int MEAS = 20,
  parameter int TXD = 60,
  parameter int RXD = 80
) (
  // bench control
  input wire logic clock,
  input wire logic rearm,
  input wire logic [3:0] busy_runs,
  input wire logic [1:0] bad_frames,
  input wire logic rx_go,
  // from sequencer
  input wire logic assess_strobe,
  input wire logic transmit_manager_enable,
  input wire logic receive_manager_enable,
  // to sequencer
  output logic assess_done,
  output logic assess_busy,
  output logic tx_frame_done,
  output logic rx_frame_end,
  output logic rx_frame_ok,
  output logic rx_ack_match,
  output logic rx_ack_wanted,
  output logic rx_pre_search
);
  int acnt = 0;
  int tcnt = 0;
  int rcnt = 0;
  int busy_left = 0;
  int bad_left = 0;
  logic fr;
  assign fr = rx_go && rcnt == RXD;
  initial {assess_done, assess_busy, tx_frame_done, rx_frame_end} = 4'h0;
  initial {rx_frame_ok, rx_ack_match, rx_ack_wanted, rx_pre_search} = 4'h0;
  // ************************************************
  // partner units
  // ************************************************
  always @(posedge clock) begin
    if (rearm) begin
      busy_left <= busy_runs;
      bad_left <= bad_frames;
    end
    assess_done <= acnt == 1;
    assess_busy <= (acnt == 1) ? busy_left > 0 : ~assess_busy;
    if (acnt == 1 && busy_left > 0) busy_left <= busy_left - 1;
    acnt <= assess_strobe ? MEAS : (acnt > 0 ? acnt - 1 : 0);
    tcnt <= transmit_manager_enable ? tcnt + 1 : 0;
    tx_frame_done <= tcnt == TXD;
    rcnt <= !receive_manager_enable ? 0 : (fr ? 10 : rcnt + 1);
    rx_pre_search <= receive_manager_enable && rcnt >= 10;
    rx_frame_end <= fr;
    rx_frame_ok <= fr ? 1'b1 : ~rx_frame_ok;
    rx_ack_match <= fr ? bad_left == 0 : ~rx_ack_match;
    rx_ack_wanted <= fr ? 1'b0 : ~rx_ack_wanted;
    if (fr && bad_left > 0) bad_left <= bad_left - 1;
  end
endmodule : radio_front_model

// ==== tb/radio_sequence_manager_test.sv ====
`timescale 1ns/10ps
module radio_sequence_manager_test;
  localparam int GAP = 60;
  localparam int SWB = 120;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp;
  logic [31:0] hrdata;
  logic tmo = 1'b0, stc = 1'b0, unl = 1'b0, pan_switch_req = 1'b0;
  logic rearm = 1'b0, rx_go = 1'b0;
  logic [3:0] busy_runs = 4'h0;
  logic [1:0] bad_frames = 2'h0;
  logic assess_done, assess_busy, tx_frame_done, rx_frame_end, rx_frame_ok, rx_ack_match, rx_ack_wanted;
  logic rx_pre_search, receive_manager_enable, transmit_manager_enable, synth_manager_enable;
  logic lock_detect_enable, pa_enable, assess_strobe, energy_detect_select, buffer_write_enable;
  logic assess_mode_one_select, assess_mode_two_select, assess_mode_three_select;
  logic [6:0] synth_integer_word;
  logic [15:0] synth_fraction_word;
  int num_errors = 0, comparisons = 0, cyc = 0, ntx, nrx, nst, ttx, tdone;
  logic bufw, rx_en_d;
  logic [3:0] sel;
  logic [2:0] ens;
  assign hready = hreadyout;
  assign ens = {receive_manager_enable, transmit_manager_enable, synth_manager_enable};
  always #4 clock = ~clock;
  radio_sequence_manager #(.RX_WARM_CYC(40), .TX_WARM_CYC(30), .GAP_CYC(GAP), .SLOT_CYC(100),
    .SWB_CYC(SWB)) dut (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .assess_done, .assess_busy, .tx_frame_done, .rx_frame_end, .rx_frame_ok,
    .rx_ack_match, .rx_ack_wanted, .rx_pre_search, .pan_switch_req, .timeout_compare_timer(tmo),
    .start_compare(stc), .synth_unlock(unl), .receive_manager_enable, .transmit_manager_enable,
    .synth_manager_enable, .lock_detect_enable, .pa_enable, .assess_strobe, .energy_detect_select,
    .assess_mode_one_select, .assess_mode_two_select, .assess_mode_three_select, .synth_integer_word,
    .synth_fraction_word, .buffer_write_enable);
  radio_front_model front (.*);
  // ************************************************
  // shared tasks
  // ************************************************
  task automatic test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [31:0] ad(input logic [2:0] i);
    return {27'h0, i, 2'h0};
  endfunction : ad
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wait_seq;
    logic [31:0] q;
    q = 32'h0;
    for (int i = 0; i < 40000 && q[seq_pkg::E_SEQ] !== 1'b1; i++) bus(1'b0, ad(seq_pkg::IDX_EVT), 32'h0, q);
  endtask : wait_seq
  task automatic start(input logic [31:0] ctrl);
    logic [31:0] q;
    ntx = 0;
    nrx = 0;
    nst = 0;
    ttx = -1;
    tdone = -1;
    bufw = 1'b0;
    bus(1'b1, ad(seq_pkg::IDX_EVT), 32'hf, q);
    rearm <= 1'b1;
    @(posedge clock);
    rearm <= 1'b0;
    bus(1'b1, ad(seq_pkg::IDX_CTRL), ctrl, q);
  endtask : start
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      test_done();
    end
    if (tx_frame_done === 1'b1) begin
      ntx++;
      ttx = cyc;
    end
    if (rx_frame_end === 1'b1) nrx++;
    if (buffer_write_enable === 1'b1) bufw = 1'b1;
    if (receive_manager_enable === 1'b1 && rx_en_d !== 1'b1 && ttx >= 0)
      chk("turnaround", 1, cyc - ttx >= seq_pkg::TURN_CYC);
    rx_en_d = receive_manager_enable;
    if (assess_done === 1'b1) tdone = cyc;
    if (assess_strobe === 1'b1) begin
      nst++;
      sel = {energy_detect_select, assess_mode_one_select, assess_mode_two_select, assess_mode_three_select};
      if (tdone >= 0) chk("gap", 1, cyc - tdone >= GAP && cyc - tdone <= GAP + 3);
    end
  end
  // ************************************************
  // scenarios
  // ************************************************
  task automatic test_reset;
    logic [31:0] q;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ad(i[2:0]), 32'h0, q);
      chk("reset register", 32'h0, q);
    end
    chk("enables", 0, ens);
    $display("test reset done");
  endtask : test_reset
  task automatic test_ccca(input int m);
    logic [31:0] q;
    busy_runs <= m[3:0];
    start({20'h0, m[1:0], 7'h0, seq_pkg::SEL_CCCA});
    wait_seq();
    chk("measurements", m + 1, nst);
    chk("mode select", 4'h8 >> (m + (m == 0)), sel);
    bus(1'b0, ad(seq_pkg::IDX_BCNT), 32'h0, q);
    chk("busy count", m, q);
    bus(1'b0, ad(seq_pkg::IDX_EVT), 32'h0, q);
    chk("events", 32'hc, q);
    bus(1'b0, ad(seq_pkg::IDX_STAT), 32'h0, q);
    chk("channel busy", 0, q[0]);
    chk("enables", 0, ens);
    $display("test ccca %0d done", m);
  endtask : test_ccca
  task automatic test_tr(input logic ack, input logic all, input logic [1:0] bad, input logic bw);
    logic [31:0] q;
    bad_frames <= bad;
    rx_go <= 1'b1;
    start({24'h0, all, 2'h0, ack, 1'b0, seq_pkg::SEL_TR});
    wait_seq();
    rx_go <= 1'b0;
    chk("transmits", 1, ntx);
    chk("frames", bad + 1, nrx);
    chk("buffer writes", bw, bufw);
    bus(1'b0, ad(seq_pkg::IDX_EVT), 32'h0, q);
    chk("events", 32'h9, q & 32'h9);
    chk("enables", 0, ens);
    $display("test tr %b%b done", ack, all);
  endtask : test_tr
  task automatic test_switch;
    logic [31:0] q;
    int n;
    bus(1'b1, ad(seq_pkg::IDX_CH0), {9'h0, 7'h11, 16'h1234}, q);
    bus(1'b1, ad(seq_pkg::IDX_CH1), {9'h0, 7'h22, 16'h5678}, q);
    start(32'h0000_0101);
    for (n = 0; n < 2000 && rx_pre_search !== 1'b1; n++) @(posedge clock);
    chk("first channel", 7'h11, synth_integer_word);
    pan_switch_req <= 1'b1;
    for (n = 0; n < 500 && synth_manager_enable !== 1'b0; n++) @(posedge clock);
    pan_switch_req <= 1'b0;
    chk("lock off", 0, lock_detect_enable);
    chk("new integer", 7'h22, synth_integer_word);
    chk("new fraction", 16'h5678, synth_fraction_word);
    for (n = 0; n < 5000 && synth_manager_enable !== 1'b1; n++) @(posedge clock);
    chk("stage a", seq_pkg::SWA_CYC, n);
    for (n = 0; n < 5000 && lock_detect_enable !== 1'b1; n++) @(posedge clock);
    chk("stage b", SWB, n);
    tmo <= 1'b1;
    @(posedge clock);
    tmo <= 1'b0;
    repeat (4) @(posedge clock);
    chk("enables", 0, ens);
    bus(1'b0, ad(seq_pkg::IDX_EVT), 32'h0, q);
    chk("no done event", 0, q[seq_pkg::E_SEQ]);
    $display("test switch done");
  endtask : test_switch
  task automatic test_tx_abort;
    logic [31:0] q;
    int n;
    start({29'h0, seq_pkg::SEL_T});
    for (n = 0; n < 500 && pa_enable !== 1'b1; n++) @(posedge clock);
    repeat (5) @(posedge clock);
    bus(1'b1, ad(seq_pkg::IDX_CTRL), 32'h0, q);
    @(posedge clock);
    chk("pa off", 0, pa_enable);
    for (n = 0; n < 1000 && transmit_manager_enable !== 1'b0; n++) @(posedge clock);
    chk("staged", 1, n >= seq_pkg::STAGE_CYC - 3 && n <= seq_pkg::STAGE_CYC + 2);
    repeat (4) @(posedge clock);
    chk("enables", 0, ens);
    $display("test tx abort done");
  endtask : test_tx_abort
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    test_reset();
    for (int m = 0; m < 4; m++) test_ccca(m);
    test_tr(1'b0, 1'b0, 2'h0, 1'b1);
    test_tr(1'b1, 1'b0, 2'h1, 1'b0);
    test_tr(1'b1, 1'b1, 2'h1, 1'b1);
    test_switch();
    test_tx_abort();
    test_done();
  end
endmodule : radio_sequence_manager_test
